// ### hdl/lfvs_pkg.sv
// lfvs_pkg: register map, limits, reset values, timing and carrier types
// for the low-frequency swing suppression parameter block.
// assumes a 16-bit parameter port and a 50 MHz system clock.

package lfvs_pkg;

	// -------------------------------------------------------------
	// port widths
	// -------------------------------------------------------------
	localparam int ADDR_W = 10; // parameter address width
	localparam int DATA_W = 16; // parameter data width
	localparam int ERR_W = 32; // position error width, pulses

	// -------------------------------------------------------------
	// parameter addresses
	// -------------------------------------------------------------
	localparam logic [9:0] ADDR_F1_FREQ = 10'h148; // first set frequency
	localparam logic [9:0] ADDR_F1_GAIN = 10'h14A; // first set gain
	localparam logic [9:0] ADDR_F2_FREQ = 10'h14C; // second set frequency
	localparam logic [9:0] ADDR_F2_GAIN = 10'h14E; // second set gain
	localparam logic [9:0] ADDR_MODE = 10'h154; // auto search mode
	localparam logic [9:0] ADDR_THR = 10'h156; // detection level
	localparam logic [9:0] ADDR_STATUS = 10'h15E; // read-only status

	// -------------------------------------------------------------
	// reset values
	// -------------------------------------------------------------
	localparam logic [15:0] RST_FREQ = 16'h03E8; // 100.0 Hz
	localparam logic [15:0] RST_GAIN = 16'h0000; // filter off
	localparam logic [15:0] RST_MODE = 16'h0000; // fixed settings
	localparam logic [15:0] RST_THR = 16'h01F4; // 500 pulses

	// -------------------------------------------------------------
	// value limits and codes
	// -------------------------------------------------------------
	localparam logic [15:0] FREQ_MIN = 16'h000A; // 1.0 Hz in 0.1 Hz
	localparam logic [15:0] FREQ_MAX = 16'h03E8; // 100.0 Hz in 0.1 Hz
	localparam logic [15:0] GAIN_MIN = 16'h0000; // off
	localparam logic [15:0] GAIN_MAX = 16'h0009; // strongest
	localparam logic [15:0] THR_MIN = 16'h0001; // pulses
	localparam logic [15:0] THR_MAX = 16'h1F40; // 8000 pulses
	localparam logic [15:0] MODE_FIXED = 16'h0000; // manual settings
	localparam logic [15:0] MODE_AUTO = 16'h0001; // automatic search
	localparam logic [15:0] FOUND_GAIN = 16'h0001; // gain after a find

	// status bit positions
	localparam int ST_BUSY = 0; // search running
	localparam int ST_F1_ON = 1; // first set active
	localparam int ST_F2_ON = 2; // second set active
	localparam int ST_FOUND = 3; // last search found a frequency
	localparam int ST_MISS = 4; // last search ended empty

	// -------------------------------------------------------------
	// timing
	// -------------------------------------------------------------
	localparam int CLK_HZ = 50_000_000; // system clock rate
	localparam int SEARCH_WINDOW_MS = 10000; // 10 s gives 0.1 Hz steps
	localparam int SEARCH_WINDOW_CYC = CLK_HZ / 1000 * SEARCH_WINDOW_MS;

	// -------------------------------------------------------------
	// carrier types
	// -------------------------------------------------------------
	// one filter set as handed to the servo loop
	typedef struct packed {
		logic active; // set engaged, else bypassed
		logic [15:0] freq; // 0.1 Hz units
		logic [15:0] gain; // 0..9
	} lfvs_filt_s;

	// outcome of one search window
	typedef struct packed {
		logic done; // one-cycle end marker
		logic found; // a swing frequency was seen
		logic [15:0] freq; // clamped frequency, 0.1 Hz
	} lfvs_result_s;

	// detector sequencer
	typedef enum logic [0:0] {
		LFVS_IDLE = 1'b0,
		LFVS_RUN = 1'b1
	} lfvs_det_e;

endpackage

// ### hdl/lfvs_swing_detect.sv
// lfvs_swing_detect: counts full swings of the position error that pass
// the detection level on both sides over a fixed window.
// assumes pos_err is synchronous to clk_sys, one sample per cycle.

`timescale 1ns/1ps
`default_nettype none

module lfvs_swing_detect
	import lfvs_pkg::*;
#(
	parameter int unsigned WINDOW_CYCLES = SEARCH_WINDOW_CYC
)
(
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic start,
	input wire logic abort,
	input wire logic [15:0] threshold,
	input wire logic signed [31:0] pos_err,
	output logic busy,
	output lfvs_result_s result
);

	// -------------------------------------------------------------
	// state
	// -------------------------------------------------------------
	typedef struct packed {
		lfvs_det_e st; // sequencer
		logic [31:0] win_cnt; // cycles into window
		logic [15:0] swing_cnt; // full swings seen
		logic low_seen; // error went below -level
		lfvs_result_s res; // registered outcome
	} lfvs_det_s;

	lfvs_det_s st_r; // registered state
	lfvs_det_s st_nxt; // next state
	logic signed [31:0] lvl_s; // level as signed pulses
	logic win_end; // last cycle of window

	assign lvl_s = $signed({16'h0000, threshold});
	assign win_end = (st_r.win_cnt == 32'(WINDOW_CYCLES - 1));

	// -------------------------------------------------------------
	// next-state logic
	// -------------------------------------------------------------
	// swing counted on each rise above +level after a dip below -level
	always_comb
	begin
		st_nxt = st_r;
		st_nxt.res.done = 1'b0;
		case (st_r.st)
			LFVS_IDLE:
			begin
				// wait for a search request
				if (start)
				begin
					st_nxt.st = LFVS_RUN;
					st_nxt.win_cnt = 32'h0000_0000;
					st_nxt.swing_cnt = 16'h0000;
					st_nxt.low_seen = 1'b0;
				end
			end
			LFVS_RUN:
			begin
				if (abort)
				begin
					// host cancelled, no result
					st_nxt.st = LFVS_IDLE;
				end
				else if (start)
				begin
					// fresh request restarts the window
					st_nxt.win_cnt = 32'h0000_0000;
					st_nxt.swing_cnt = 16'h0000;
					st_nxt.low_seen = 1'b0;
				end
				else
				begin
					st_nxt.win_cnt = st_r.win_cnt + 32'h0000_0001;
					// vibration judged by error against level
					if (pos_err < -lvl_s)
						st_nxt.low_seen = 1'b1;
					else if (pos_err > lvl_s && st_r.low_seen)
					begin
						st_nxt.low_seen = 1'b0;
						if (st_r.swing_cnt != 16'hFFFF)
							st_nxt.swing_cnt = st_r.swing_cnt + 16'h0001;
					end
					if (win_end)
					begin
						// below 1.0 Hz counts as nothing found
						st_nxt.st = LFVS_IDLE;
						st_nxt.res.done = 1'b1;
						st_nxt.res.found = (st_r.swing_cnt >= FREQ_MIN);
						// clamp into the parameter range
						if (st_r.swing_cnt > FREQ_MAX)
							st_nxt.res.freq = FREQ_MAX;
						else if (st_r.swing_cnt < FREQ_MIN)
							st_nxt.res.freq = FREQ_MIN;
						else
							st_nxt.res.freq = st_r.swing_cnt;
					end
				end
			end
			default:
			begin
				st_nxt.st = LFVS_IDLE;
			end
		endcase
	end

	// -------------------------------------------------------------
	// state register
	// -------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end

	assign busy = (st_r.st == LFVS_RUN);
	assign result = st_r.res;

	// -------------------------------------------------------------
	// assertions
	// -------------------------------------------------------------
	a_result_clamped: assert property (@(posedge clk_sys) disable iff (!nrst)
		result.done |-> (result.freq >= FREQ_MIN && result.freq <= FREQ_MAX))
		else $error("search result outside frequency range");

	a_found_band: assert property (@(posedge clk_sys) disable iff (!nrst)
		(st_r.st == LFVS_RUN && win_end && !abort && !start)
		|=> result.done && (result.found == ($past(st_r.swing_cnt) >= FREQ_MIN)))
		else $error("found flag does not match swing count");

endmodule

`default_nettype wire

// ### hdl/lfvs_top.sv
// lfvs_top: parameter registers, auto search control and filter set
// outputs for two low-frequency swing suppression filters.
// assumes a host on the parameter port and position error in pulses.
//
// The plain strobed port was chosen for this implementation.

`timescale 1ns/1ps
`default_nettype none

module lfvs_top
	import lfvs_pkg::*;
#(
	parameter int unsigned WINDOW_CYCLES = SEARCH_WINDOW_CYC
)
(
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic [9:0] addr,
	input wire logic [15:0] wdata,
	input wire logic wr_en,
	input wire logic rd_en,
	output logic [15:0] rdata,
	input wire logic pos_mode,
	input wire logic signed [31:0] pos_err,
	output lfvs_filt_s filt1,
	output lfvs_filt_s filt2,
	output logic search_busy
);

	// -------------------------------------------------------------
	// state
	// -------------------------------------------------------------
	typedef struct packed {
		logic [15:0] f1_freq; // first set frequency
		logic [15:0] f1_gain; // first set gain
		logic [15:0] f2_freq; // second set frequency
		logic [15:0] f2_gain; // second set gain
		logic [15:0] mode; // auto search mode
		logic [15:0] thr; // detection level
		logic last_found; // last search found
		logic last_miss; // last search ended empty
		logic [15:0] rdata; // read data, one cycle late
		lfvs_filt_s filt1; // registered first set output
		lfvs_filt_s filt2; // registered second set output
	} lfvs_top_s;

	lfvs_top_s st_r; // registered state
	lfvs_top_s st_nxt; // next state
	logic det_start; // begin a search window
	logic det_abort; // cancel a running search
	logic det_busy; // detector is counting
	lfvs_result_s det_res; // detector outcome
	logic wr_mode; // host writes the mode field
	logic wr_f1; // host writes a first set field

	// -------------------------------------------------------------
	// helpers
	// -------------------------------------------------------------
	// bound a written value into its legal range
	function automatic logic [15:0] clamp16(
		input logic [15:0] v,
		input logic [15:0] lo,
		input logic [15:0] hi
	);
		logic [15:0] r;
		r = v;
		if (v < lo)
			r = lo;
		else if (v > hi)
			r = hi;
		return r;
	endfunction

	assign wr_mode = wr_en && (addr == ADDR_MODE);
	assign wr_f1 = wr_en && (addr == ADDR_F1_FREQ || addr == ADDR_F1_GAIN);

	// -------------------------------------------------------------
	// swing detector
	// -------------------------------------------------------------
	lfvs_swing_detect #(
		.WINDOW_CYCLES(WINDOW_CYCLES)
	) u_detect (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.start(det_start),
		.abort(det_abort),
		.threshold(st_r.thr),
		.pos_err(pos_err),
		.busy(det_busy),
		.result(det_res)
	);

	// -------------------------------------------------------------
	// next-state logic
	// -------------------------------------------------------------
	// host writes, search bookkeeping, read mux, filter outputs
	always_comb
	begin
		st_nxt = st_r;
		det_start = 1'b0;
		det_abort = 1'b0;

		// host writes; out of range values are clamped, bad mode codes ignored
		if (wr_en)
		begin
			case (addr)
				ADDR_F1_FREQ:
					st_nxt.f1_freq = clamp16(wdata, FREQ_MIN, FREQ_MAX);
				ADDR_F1_GAIN:
					st_nxt.f1_gain = clamp16(wdata, GAIN_MIN, GAIN_MAX);
				ADDR_F2_FREQ:
					st_nxt.f2_freq = clamp16(wdata, FREQ_MIN, FREQ_MAX);
				ADDR_F2_GAIN:
					st_nxt.f2_gain = clamp16(wdata, GAIN_MIN, GAIN_MAX);
				ADDR_THR:
					st_nxt.thr = clamp16(wdata, THR_MIN, THR_MAX);
				ADDR_MODE:
				begin
					// only 0 is always taken, 1 only in position mode, others ignored
					if (wdata == MODE_FIXED)
					begin
						st_nxt.mode = MODE_FIXED;
						det_abort = 1'b1;
					end
					else if (wdata == MODE_AUTO && pos_mode)
					begin
						// start or restart a search
						st_nxt.mode = MODE_AUTO;
						st_nxt.last_found = 1'b0;
						st_nxt.last_miss = 1'b0;
						det_start = 1'b1;
					end
				end
				default:
				begin
					// unmapped or read-only address, write dropped
				end
			endcase
		end

		// search end; a mode write in the same cycle wins
		if (det_res.done)
		begin
			if (!wr_mode)
				st_nxt.mode = MODE_FIXED;
			st_nxt.last_found = det_res.found;
			st_nxt.last_miss = !det_res.found;
			if (det_res.found)
			begin
				// found frequency overrides a host write here
				st_nxt.f1_freq = det_res.freq;
				st_nxt.f1_gain = FOUND_GAIN;
			end
		end
		else if (!pos_mode && st_r.mode == MODE_AUTO && !wr_mode)
		begin
			// leaving position mode cancels the search with no result
			st_nxt.mode = MODE_FIXED;
			det_abort = 1'b1;
		end

		// read data, valid the cycle after the strobe
		st_nxt.rdata = 16'h0000;
		if (rd_en)
		begin
			case (addr)
				ADDR_F1_FREQ: st_nxt.rdata = st_r.f1_freq;
				ADDR_F1_GAIN: st_nxt.rdata = st_r.f1_gain;
				ADDR_F2_FREQ: st_nxt.rdata = st_r.f2_freq;
				ADDR_F2_GAIN: st_nxt.rdata = st_r.f2_gain;
				ADDR_MODE: st_nxt.rdata = st_r.mode;
				ADDR_THR: st_nxt.rdata = st_r.thr;
				ADDR_STATUS:
				begin
					st_nxt.rdata[ST_BUSY] = det_busy;
					st_nxt.rdata[ST_F1_ON] = st_r.filt1.active;
					st_nxt.rdata[ST_F2_ON] = st_r.filt2.active;
					st_nxt.rdata[ST_FOUND] = st_r.last_found;
					st_nxt.rdata[ST_MISS] = st_r.last_miss;
				end
				default: st_nxt.rdata = 16'h0000; // unmapped reads zero
			endcase
		end

		// two independent sets, each bypassed at gain zero
		st_nxt.filt1.active = pos_mode && (st_r.f1_gain != 16'h0000);
		st_nxt.filt1.freq = st_r.f1_freq;
		st_nxt.filt1.gain = st_r.f1_gain;
		st_nxt.filt2.active = pos_mode && (st_r.f2_gain != 16'h0000);
		st_nxt.filt2.freq = st_r.f2_freq;
		st_nxt.filt2.gain = st_r.f2_gain;
	end

	// -------------------------------------------------------------
	// state register
	// -------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			st_r <= '0;
			st_r.f1_freq <= RST_FREQ;
			st_r.f1_gain <= RST_GAIN;
			st_r.f2_freq <= RST_FREQ;
			st_r.f2_gain <= RST_GAIN;
			st_r.mode <= RST_MODE;
			st_r.thr <= RST_THR;
			st_r.filt1.freq <= RST_FREQ;
			st_r.filt2.freq <= RST_FREQ;
		end
		else
			st_r <= st_nxt;
	end

	// -------------------------------------------------------------
	// outputs
	// -------------------------------------------------------------
	assign rdata = st_r.rdata;
	assign filt1 = st_r.filt1;
	assign filt2 = st_r.filt2;
	assign search_busy = det_busy;

	// -------------------------------------------------------------
	// assertions
	// -------------------------------------------------------------
	a_gain_bypass: assert property (@(posedge clk_sys) disable iff (!nrst)
		(st_r.f1_gain == 16'h0000 || st_r.f2_gain == 16'h0000)
		|=> !(filt1.active && $past(st_r.f1_gain) == 16'h0000)
		&& !(filt2.active && $past(st_r.f2_gain) == 16'h0000))
		else $error("filter set active with zero gain");

	a_mode_gate: assert property (@(posedge clk_sys) disable iff (!nrst)
		!pos_mode |=> !filt1.active && !filt2.active)
		else $error("filter active outside position mode");

	a_freq_range: assert property (@(posedge clk_sys) disable iff (!nrst)
		st_r.f1_freq >= FREQ_MIN && st_r.f1_freq <= FREQ_MAX
		&& st_r.f2_freq >= FREQ_MIN && st_r.f2_freq <= FREQ_MAX)
		else $error("frequency parameter out of range");

	a_gain_range: assert property (@(posedge clk_sys) disable iff (!nrst)
		st_r.f1_gain <= GAIN_MAX && st_r.f2_gain <= GAIN_MAX)
		else $error("gain parameter out of range");

	a_mode_values: assert property (@(posedge clk_sys) disable iff (!nrst)
		st_r.mode == MODE_FIXED || st_r.mode == MODE_AUTO)
		else $error("mode field holds illegal value");

	a_level_range: assert property (@(posedge clk_sys) disable iff (!nrst)
		st_r.thr >= THR_MIN && st_r.thr <= THR_MAX)
		else $error("detection level out of range");

	a_search_start: assert property (@(posedge clk_sys) disable iff (!nrst)
		(wr_mode && wdata == MODE_AUTO && pos_mode)
		|=> search_busy && st_r.mode == MODE_AUTO)
		else $error("search did not start on mode write");

	a_found_store: assert property (@(posedge clk_sys) disable iff (!nrst)
		(det_res.done && det_res.found && !wr_mode)
		|=> st_r.mode == MODE_FIXED && st_r.f1_gain == FOUND_GAIN
		&& st_r.f1_freq == $past(det_res.freq))
		else $error("found frequency not stored");

	a_miss_clear: assert property (@(posedge clk_sys) disable iff (!nrst)
		(det_res.done && !det_res.found && !wr_mode && !wr_f1)
		|=> st_r.mode == MODE_FIXED && $stable(st_r.f1_gain))
		else $error("empty search left mode set or moved gain");

	a_read_late: assert property (@(posedge clk_sys) disable iff (!nrst)
		(rd_en && addr == ADDR_F2_GAIN) |=> rdata == $past(st_r.f2_gain))
		else $error("second set gain read back wrong");

	c_search_found: cover property (@(posedge clk_sys) disable iff (!nrst)
		det_res.done && det_res.found);

	c_search_miss: cover property (@(posedge clk_sys) disable iff (!nrst)
		det_res.done && !det_res.found);

	c_search_abort: cover property (@(posedge clk_sys) disable iff (!nrst)
		search_busy && wr_mode && wdata == MODE_FIXED);

	c_both_active: cover property (@(posedge clk_sys) disable iff (!nrst)
		filt1.active && filt2.active);

endmodule

`default_nettype wire

// ### bench/lfvs_host_model.sv
// lfvs_host_model: host controller on the parameter port of lfvs_top.
// assumes a shared clk_sys; strobes change by nba after a rising edge.

`timescale 1ns/1ps
`default_nettype none

module lfvs_host_model
	import lfvs_pkg::*;
(
	input wire logic clk_sys,
	output logic [9:0] addr,
	output logic [15:0] wdata,
	output logic wr_en,
	output logic rd_en,
	input wire logic [15:0] rdata
);
	// ---------------------------------------------------------
	// idle bus
	// ---------------------------------------------------------
	initial
	begin
		addr = 10'h000;
		wdata = 16'h0000;
		wr_en = 1'b0;
		rd_en = 1'b0;
	end

	// one-cycle write; released lines show the inverse value
	task automatic wr(input logic [9:0] a, input logic [15:0] d);
		@(posedge clk_sys);
		addr <= a;
		wdata <= d;
		wr_en <= 1'b1;
		@(posedge clk_sys);
		wr_en <= 1'b0;
		addr <= ~a;
		wdata <= ~d;
	endtask

	// one-cycle read; data taken in the cycle after the strobe
	task automatic rd(input logic [9:0] a, output logic [15:0] d);
		@(posedge clk_sys);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge clk_sys);
		rd_en <= 1'b0;
		addr <= ~a;
		@(negedge clk_sys);
		d = rdata;
	endtask

	// both sets off, level set, then search started
	task automatic search(input logic [15:0] lvl);
		wr(ADDR_F1_GAIN, GAIN_MIN);
		wr(ADDR_F2_GAIN, GAIN_MIN);
		wr(ADDR_THR, lvl);
		wr(ADDR_MODE, MODE_AUTO);
	endtask
endmodule

`default_nettype wire

// ### bench/testbench.sv
// testbench: self-checking bench for lfvs_top with a host model.
// assumes a short search window; frequency equals raw swing count.

`timescale 1ns/1ps
`default_nettype none

module testbench
	import lfvs_pkg::*;
;

	// ---------------------------------------------------------
	// signals
	// ---------------------------------------------------------
	localparam int unsigned WIN = 4400; // shortened search window
	typedef struct {logic [9:0] a; logic [15:0] d; logic [15:0] e;} lfvs_row_s;
	logic clk_sys, nrst, wr_en, rd_en, pos_mode, search_busy;
	logic [9:0] addr;
	logic [15:0] wdata, rdata, rv;
	logic signed [31:0] pos_err;
	lfvs_filt_s filt1, filt2;
	int fail_count, checks;
	// write value, expected readback
	lfvs_row_s rows[15] = '{
		'{ADDR_F1_FREQ, 16'h0005, 16'h000A}, '{ADDR_F1_FREQ, 16'h07D0, 16'h03E8},
		'{ADDR_F1_FREQ, 16'h01F4, 16'h01F4}, '{ADDR_F1_GAIN, 16'h000C, 16'h0009},
		'{ADDR_F1_GAIN, 16'h0003, 16'h0003}, '{ADDR_F2_FREQ, 16'h000A, 16'h000A},
		'{ADDR_F2_FREQ, 16'h03E9, 16'h03E8}, '{ADDR_F2_GAIN, 16'h0009, 16'h0009},
		'{ADDR_THR, 16'h0000, 16'h0001}, '{ADDR_THR, 16'h2328, 16'h1F40},
		'{ADDR_THR, 16'h1F40, 16'h1F40}, '{ADDR_THR, 16'h012C, 16'h012C},
		'{ADDR_MODE, 16'h0002, 16'h0000}, '{10'h100, 16'h0005, 16'h0000},
		'{ADDR_F2_GAIN, 16'h0000, 16'h0000}};

	// ---------------------------------------------------------
	// instances and clock
	// ---------------------------------------------------------
	lfvs_top #(.WINDOW_CYCLES(WIN)) lfvs_top_i (.clk_sys(clk_sys),
		.nrst(nrst), .addr(addr), .wdata(wdata), .wr_en(wr_en),
		.rd_en(rd_en), .rdata(rdata), .pos_mode(pos_mode),
		.pos_err(pos_err), .filt1(filt1), .filt2(filt2),
		.search_busy(search_busy));
	lfvs_host_model lfvs_host_model_i (.clk_sys(clk_sys), .addr(addr),
		.wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata));

	initial clk_sys = 1'b0;
	always #10 clk_sys = ~clk_sys;

	// ---------------------------------------------------------
	// helpers
	// ---------------------------------------------------------
	// verdict and end of run
	task automatic summarize();
		$display("checks %0d mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// compare seen against expected
	task automatic check(input logic [15:0] s, input logic [15:0] e,
		input string m);
		checks++;
		if (s !== e)
		begin
			fail_count++;
			$display("mismatch at %0t: %s seen %h expected %h", $time, m, s, e);
		end
	endtask

	// read one parameter and compare
	task automatic rdchk(input logic [9:0] a, input logic [15:0] e);
		lfvs_host_model_i.rd(a, rv);
		check(rv, e, "register readback");
	endtask

	// full swings past +-amp, four cycles each
	task automatic swing(input int amp, input int n);
		for (int i = 0; i < n; i++)
		begin
			@(posedge clk_sys);
			pos_err <= -amp;
			@(posedge clk_sys);
			@(posedge clk_sys);
			pos_err <= amp;
			@(posedge clk_sys);
		end
		@(posedge clk_sys);
		pos_err <= 32'sh0;
	endtask

	// start a search, swing, wait for the end under a bound
	task automatic run(input logic [15:0] lvl, input int amp, input int n);
		int k;
		lfvs_host_model_i.search(lvl);
		#1;
		check(16'(search_busy), 16'h0001, "busy after start");
		rdchk(ADDR_MODE, MODE_AUTO);
		swing(amp, n);
		// busy looked at mid-cycle, away from the edge that moves it
		for (k = 0; k < WIN + 100 && search_busy !== 1'b0; k++)
			@(negedge clk_sys);
		if (k >= WIN + 100)
		begin
			fail_count++;
			summarize();
		end
		rdchk(ADDR_MODE, MODE_FIXED);
	endtask

	// ---------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------
	initial
	begin
		nrst = 1'b0;
		pos_mode = 1'b0;
		pos_err = 32'sh0;
		fail_count = 0;
		checks = 0;
		repeat (12) @(posedge clk_sys);
		nrst <= 1'b1;
		// reset values
		check(16'(filt1.active), 16'h0000, "filt1 off at reset");
		check(filt2.freq, RST_FREQ, "filt2 freq at reset");
		rdchk(ADDR_F1_FREQ, RST_FREQ);
		rdchk(ADDR_F2_FREQ, RST_FREQ);
		rdchk(ADDR_F1_GAIN, RST_GAIN);
		rdchk(ADDR_F2_GAIN, RST_GAIN);
		rdchk(ADDR_MODE, RST_MODE);
		rdchk(ADDR_THR, RST_THR);
		@(negedge clk_sys);
		check(rdata, 16'h0000, "rdata after its cycle");
		// limits, refused mode codes, unmapped place
		foreach (rows[i])
		begin
			lfvs_host_model_i.wr(rows[i].a, rows[i].d);
			rdchk(rows[i].a, rows[i].e);
		end
		// independent sets, bypass at gain zero, position mode only
		@(posedge clk_sys);
		pos_mode <= 1'b1;
		lfvs_host_model_i.wr(ADDR_F1_FREQ, 16'h00FA);
		repeat (2) @(negedge clk_sys);
		check(16'(filt1.active), 16'h0001, "filt1 engaged");
		check(filt1.gain, 16'h0003, "filt1 gain");
		check(filt1.freq, 16'h00FA, "filt1 freq");
		check(16'(filt2.active), 16'h0000, "filt2 bypassed");
		lfvs_host_model_i.wr(ADDR_F2_GAIN, 16'h0009);
		repeat (2) @(negedge clk_sys);
		check(16'(filt2.active), 16'h0001, "filt2 engaged");
		check(filt2.gain, 16'h0009, "filt2 gain");
		check(filt2.freq, FREQ_MAX, "filt2 freq");
		check(filt1.gain, 16'h0003, "filt1 untouched");
		@(posedge clk_sys);
		pos_mode <= 1'b0;
		repeat (3) @(negedge clk_sys);
		check(16'(filt1.active), 16'h0000, "off outside position");
		lfvs_host_model_i.wr(ADDR_MODE, MODE_AUTO);
		#1;
		check(16'(search_busy), 16'h0000, "no search outside");
		rdchk(ADDR_MODE, MODE_FIXED);
		// searches
		@(posedge clk_sys);
		pos_mode <= 1'b1;
		run(16'h01F4, 600, 20);
		rdchk(ADDR_F1_FREQ, 16'h0014);
		rdchk(ADDR_F1_GAIN, FOUND_GAIN);
		// status: first set active, last search found
		rdchk(ADDR_STATUS, 16'h000A);
		run(16'h01F4, 600, 1050);
		rdchk(ADDR_F1_FREQ, FREQ_MAX);
		run(16'h01F4, 500, 20);
		rdchk(ADDR_F1_GAIN, GAIN_MIN);
		// status: both sets off, last search ended empty
		rdchk(ADDR_STATUS, 16'h0010);
		rdchk(ADDR_F1_FREQ, FREQ_MAX);
		run(16'h01F3, 500, 15);
		rdchk(ADDR_F1_FREQ, 16'h000F);
		rdchk(ADDR_F1_GAIN, FOUND_GAIN);
		// status while busy, restart by mode 1, abort by mode 0
		lfvs_host_model_i.search(16'h01F4);
		rdchk(ADDR_STATUS, 16'h0001);
		lfvs_host_model_i.wr(ADDR_MODE, MODE_AUTO);
		#1;
		check(16'(search_busy), 16'h0001, "busy after restart");
		lfvs_host_model_i.wr(ADDR_MODE, MODE_FIXED);
		#1;
		check(16'(search_busy), 16'h0000, "abort on mode 0");
		rdchk(ADDR_MODE, MODE_FIXED);
		rdchk(ADDR_STATUS, 16'h0000);
		// leaving position mode aborts a search
		lfvs_host_model_i.search(16'h01F4);
		@(posedge clk_sys);
		pos_mode <= 1'b0;
		repeat (3) @(negedge clk_sys);
		check(16'(search_busy), 16'h0000, "abort on mode loss");
		rdchk(ADDR_MODE, MODE_FIXED);
		summarize();
	end
endmodule

`default_nettype wire
